//--- core/gmp_port.sv
// GMII/MII MAC-facing data port of a triple-speed transceiver
// assumes GTX_CLK comes from the MAC; config and line inputs come from core logic on CLK
`timescale 1ns/1ps
`include "gmp_regs.svh"

// Summary of operation
// - byte GMII at gigabit, nibble MII otherwise
// - MII ignores transmit bits seven to four
// - transmit error marks current frame errored
// - transmit error line requests low power idle
// - GMII clocks transmit on GTX_CLK; MII ignores it
// - device drives TX_CLK in MII only
// - collision output only in half duplex
// - carrier sense output only in half duplex
// - eight receive lines, upper nibble low MII
// - receive valid high only with decoded data
// - receive error flags errored frame
// - receive error signals low power idle
// - pair A transmits MDI, receives MDI-X
// - pair B receives MDI, transmits MDI-X
// - pairs C and D unused below gigabit
// - gigabit uses all four pairs both ways
module gmp_port #(
   parameter int unsigned TX_DIV = `GMP_TX_CLK_DIV,
   parameter int unsigned RX_DIV = `GMP_RX_CLK_DIV
) (
   // core clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RSTN,
   // MAC transmit pins
   input  wire logic                 GTX_CLK,
   input  wire logic [7:0]           TXD,
   input  wire logic                 TX_EN,
   input  wire logic                 TX_ER,
   output logic                      TX_CLK,
   // MAC receive pins
   output logic                      RX_CLK,
   output logic [7:0]                RXD,
   output logic                      RX_DV,
   output logic                      RX_ER,
   output logic                      CRS,
   output logic                      COL,
   // link configuration
   input  wire logic                 GIG_MODE,
   input  wire logic                 HALF_DUPLEX,
   input  wire logic                 MDIX,
   // line status
   input  wire logic                 LINE_CARRIER,
   input  wire logic                 LINE_COLLISION,
   // receive symbols from the decoder
   input  gmp_pkg::gmp_sym_t         RX_SYM,
   output logic                      RX_TAKE,
   // transmit symbols to the encoder
   output gmp_pkg::gmp_sym_t         TX_SYM,
   output logic                      TX_FRAME_BAD,
   output logic                      TX_OVERRUN,
   // media pair roles, bit 0 is pair A
   output logic [3:0]                PAIR_TX_EN,
   output logic [3:0]                PAIR_RX_EN
);
   localparam int unsigned TXW = (TX_DIV > 2) ? $clog2(TX_DIV) : 1;

   logic [TXW-1:0]            tx_cnt;
   logic [TXW-1:0]            next_tx_cnt;
   logic                      mii_stb;
   gmp_pkg::gmp_gmii_t        pin_meta;
   gmp_pkg::gmp_gmii_t        pin_sync;
   gmp_pkg::gmp_gmii_t        hold;
   logic                      req_tog;
   logic                      req_s1;
   logic                      req_s2;
   logic                      req_s3;
   logic                      ack_tog;
   logic                      ovr_meta;
   logic                      gtx_ovr;
   logic                      stb;
   gmp_pkg::gmp_gmii_t        word;
   logic                      word_gig;
   logic                      err_sticky;
   gmp_pkg::gmp_tx_state_t    state;
   gmp_pkg::gmp_tx_state_t    next_state;

   function automatic logic is_lpi(input gmp_pkg::gmp_gmii_t w);
      is_lpi = !w.en && w.er && (w.d == `GMP_LPI_CODE);
   endfunction : is_lpi

   // MII transmit pins are resynchronised before use
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {TX_EN, TX_ER, TXD};
         pin_sync <= pin_meta;
      end
   end

   // TX_CLK divider, parked low in GMII mode
   assign next_tx_cnt = (tx_cnt == TXW'(TX_DIV - 1)) ? '0 : tx_cnt + 1'b1;
   // TX_DIV of 4 or more leaves room for the two-stage input delay
   assign mii_stb = !GIG_MODE && (next_tx_cnt == TXW'(TX_DIV / 2));

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_cnt <= '0;
         TX_CLK <= 1'b0;
      end else if (GIG_MODE) begin
         tx_cnt <= '0;
         TX_CLK <= 1'b0;
      end else begin
         tx_cnt <= next_tx_cnt;
         TX_CLK <= next_tx_cnt >= TXW'(TX_DIV / 2);
      end
   end

   // GMII capture runs on the MAC clock
   gmp_tx_sampler u_tx_sampler (
      .gtx_clk (GTX_CLK),
      .rstn    (RSTN),
      .gig     (GIG_MODE),
      .ack_tog (ack_tog),
      .txd     (TXD),
      .tx_en   (TX_EN),
      .tx_er   (TX_ER),
      .req_tog (req_tog),
      .hold    (hold),
      .overrun (gtx_ovr)
   );

   // toggle handshake into the core domain; hold is stable while req differs
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         req_s1   <= 1'b0;
         req_s2   <= 1'b0;
         req_s3   <= 1'b0;
         ack_tog  <= 1'b0;
         ovr_meta <= 1'b0;
         TX_OVERRUN <= 1'b0;
      end else begin
         req_s1   <= req_tog;
         req_s2   <= req_s1;
         req_s3   <= req_s2;
         ack_tog  <= req_s2;
         ovr_meta <= gtx_ovr;
         TX_OVERRUN <= ovr_meta;
      end
   end

   // one beat per strobe from whichever clock the mode selects
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         stb      <= 1'b0;
         word     <= '0;
         word_gig <= 1'b0;
      end else begin
         word_gig <= GIG_MODE;
         if (GIG_MODE) begin
            stb  <= req_s2 != req_s3;
            word <= hold;
         end else begin
            stb  <= mii_stb;
            word <= {pin_sync.en, pin_sync.er, pin_sync.d & `GMP_NIB_MASK};
         end
      end
   end

   // frame tracking
   always_comb begin
      next_state = state;
      case (state)
         gmp_pkg::GMP_TX_IDLE: begin
            if (stb && word.en)
               next_state = gmp_pkg::GMP_TX_FRAME;
            else if (stb && is_lpi(word))
               next_state = gmp_pkg::GMP_TX_LPI;
         end
         gmp_pkg::GMP_TX_FRAME: begin
            if (stb && !word.en)
               next_state = is_lpi(word) ? gmp_pkg::GMP_TX_LPI : gmp_pkg::GMP_TX_IDLE;
         end
         gmp_pkg::GMP_TX_LPI: begin
            if (stb && !is_lpi(word))
               next_state = word.en ? gmp_pkg::GMP_TX_FRAME : gmp_pkg::GMP_TX_IDLE;
         end
         default: next_state = gmp_pkg::GMP_TX_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN)
         state <= gmp_pkg::GMP_TX_IDLE;
      else
         state <= next_state;
   end

   // an error beat taints the rest of its frame
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN)
         err_sticky <= 1'b0;
      else if (stb && !word.en)
         err_sticky <= 1'b0;
      else if (stb && word.en && word.er)
         err_sticky <= 1'b1;
   end

   // encoder side; only beats with enable high carry data
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         TX_SYM       <= '0;
         TX_FRAME_BAD <= 1'b0;
      end else begin
         TX_SYM.valid <= stb && word.en;
         TX_SYM.err   <= stb && word.en && (word.er || err_sticky);
         TX_SYM.lpi   <= next_state == gmp_pkg::GMP_TX_LPI;
         if (stb)
            TX_SYM.data <= word.en ? word.d : 8'h00;
         TX_FRAME_BAD <= stb && !word.en && (state == gmp_pkg::GMP_TX_FRAME)
                         && err_sticky;
      end
   end

   // half duplex line indications
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         CRS <= 1'b0;
         COL <= 1'b0;
      end else begin
         CRS <= HALF_DUPLEX && LINE_CARRIER;
         COL <= HALF_DUPLEX && LINE_COLLISION;
      end
   end

   // pair roles by speed and crossover
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PAIR_TX_EN <= `GMP_PAIRS_NONE;
         PAIR_RX_EN <= `GMP_PAIRS_NONE;
      end else if (GIG_MODE) begin
         PAIR_TX_EN <= `GMP_PAIRS_ALL;
         PAIR_RX_EN <= `GMP_PAIRS_ALL;
      end else begin
         // C and D stay out of both masks
         PAIR_TX_EN <= MDIX ? `GMP_PAIR_B : `GMP_PAIR_A;
         PAIR_RX_EN <= MDIX ? `GMP_PAIR_A : `GMP_PAIR_B;
      end
   end

   // receive path toward the MAC
   gmp_rx_driver #(
      .DIV (RX_DIV)
   ) u_rx_driver (
      .clk    (CLK),
      .rstn   (RSTN),
      .gig    (GIG_MODE),
      .sym    (RX_SYM),
      .rx_clk (RX_CLK),
      .rxd    (RXD),
      .rx_dv  (RX_DV),
      .rx_er  (RX_ER),
      .take   (RX_TAKE)
   );

   mii_upper_a: assert property (@(posedge CLK) disable iff (!RSTN)
      TX_SYM.valid && !$past(word_gig) |-> TX_SYM.data[7:4] == 4'h0)
      else $error("upper transmit nibble passed in MII mode");

   tx_valid_a: assert property (@(posedge CLK) disable iff (!RSTN)
      TX_SYM.valid |-> $past(stb) && $past(word.en))
      else $error("transmit symbol without enable");

   // next beat of the same frame, no frame end between, must still carry the error
   frame_err_a: assert property (@(posedge CLK) disable iff (!RSTN)
      stb && word.en && word.er ##1 (!stb)[*3] ##1 stb && word.en |=> TX_SYM.err)
      else $error("errored frame lost its error mark");

   lpi_req_a: assert property (@(posedge CLK) disable iff (!RSTN)
      stb && !word.en && word.er && word.d == `GMP_LPI_CODE |=> TX_SYM.lpi)
      else $error("low power idle request not recognised");

   gtx_ignored_a: assert property (@(posedge CLK) disable iff (!RSTN)
      !GIG_MODE && !mii_stb ##1 !GIG_MODE |=> !TX_SYM.valid)
      else $error("beat taken in MII mode off the TX_CLK edge");

   txclk_park_a: assert property (@(posedge CLK) disable iff (!RSTN)
      GIG_MODE ##1 GIG_MODE |-> !TX_CLK ##1 !TX_CLK || !GIG_MODE)
      else $error("TX_CLK toggles in GMII mode");

   col_half_a: assert property (@(posedge CLK) disable iff (!RSTN)
      COL |-> $past(HALF_DUPLEX) && $past(LINE_COLLISION))
      else $error("collision shown outside half duplex");

   crs_half_a: assert property (@(posedge CLK) disable iff (!RSTN)
      HALF_DUPLEX && LINE_CARRIER |=> CRS ##0 !(CRS && !$past(HALF_DUPLEX)))
      else $error("carrier sense wrong for duplex");

   pair_mii_a: assert property (@(posedge CLK) disable iff (!RSTN)
      !GIG_MODE |=> (PAIR_TX_EN | PAIR_RX_EN) == (`GMP_PAIR_A | `GMP_PAIR_B)
      && PAIR_TX_EN == ($past(MDIX) ? `GMP_PAIR_B : `GMP_PAIR_A))
      else $error("pair roles wrong below gigabit");

   pair_gig_a: assert property (@(posedge CLK) disable iff (!RSTN)
      GIG_MODE |=> PAIR_TX_EN == `GMP_PAIRS_ALL && PAIR_RX_EN == `GMP_PAIRS_ALL)
      else $error("gigabit does not use all pairs");

endmodule : gmp_port

//--- core/gmp_regs.svh
// constants for the GMII/MII port: dividers, line codes, pair masks
// assumes the core clock runs at GMP_CLK_HZ
`ifndef GMP_REGS_SVH
`define GMP_REGS_SVH

`define GMP_CLK_HZ      20000000
`define GMP_TX_CLK_DIV  4
`define GMP_RX_CLK_DIV  4
`define GMP_LPI_CODE    8'h01
`define GMP_NIB_MASK    8'h0F
`define GMP_PAIRS_ALL   4'hF
`define GMP_PAIR_A      4'h1
`define GMP_PAIR_B      4'h2
`define GMP_PAIRS_NONE  4'h0

`endif

//--- core/gmp_pkg.sv
// types shared by the GMII/MII port modules
// assumes nothing beyond a SystemVerilog compiler
package gmp_pkg;

   // one transmit beat as the MAC presents it
   typedef struct packed {
      logic       en;
      logic       er;
      logic [7:0] d;
   } gmp_gmii_t;

   // one symbol on the core side, either direction
   typedef struct packed {
      logic       valid;
      logic       err;
      logic       lpi;
      logic [7:0] data;
   } gmp_sym_t;

   typedef enum logic [2:0] {
      GMP_TX_IDLE  = 3'b001,
      GMP_TX_FRAME = 3'b010,
      GMP_TX_LPI   = 3'b100
   } gmp_tx_state_t;

endpackage : gmp_pkg

//--- core/gmp_tx_sampler.sv
// GMII transmit capture on the MAC's transmit clock
// assumes pins change on GTX_CLK; gig and ack come from the core domain
`timescale 1ns/1ps
module gmp_tx_sampler (
   // link clock and reset
   input  wire logic                 gtx_clk,
   input  wire logic                 rstn,
   // from core domain
   input  wire logic                 gig,
   input  wire logic                 ack_tog,
   // MAC pins
   input  wire logic [7:0]           txd,
   input  wire logic                 tx_en,
   input  wire logic                 tx_er,
   // to core domain
   output logic                      req_tog,
   output gmp_pkg::gmp_gmii_t        hold,
   output logic                      overrun
);
   logic               rs_meta;
   logic               rs_n;
   logic               gig_meta;
   logic               gig_s;
   logic               ack_meta;
   logic               ack_s;
   logic               busy;
   gmp_pkg::gmp_gmii_t cap;

   // release of reset is retimed to the link clock
   always_ff @(posedge gtx_clk or negedge rstn) begin
      if (!rstn) begin
         rs_meta <= 1'b0;
         rs_n    <= 1'b0;
      end else begin
         rs_meta <= 1'b1;
         rs_n    <= rs_meta;
      end
   end

   always_ff @(posedge gtx_clk or negedge rs_n) begin
      if (!rs_n) begin
         gig_meta <= 1'b0;
         gig_s    <= 1'b0;
         ack_meta <= 1'b0;
         ack_s    <= 1'b0;
      end else begin
         gig_meta <= gig;
         gig_s    <= gig_meta;
         ack_meta <= ack_tog;
         ack_s    <= ack_meta;
      end
   end

   assign busy = req_tog != ack_s;

   // every beat is captured on the MAC clock
   always_ff @(posedge gtx_clk or negedge rs_n) begin
      if (!rs_n) begin
         cap     <= '0;
         hold    <= '0;
         req_tog <= 1'b0;
         overrun <= 1'b0;
      end else begin
         cap <= {tx_en, tx_er, txd};
         if (gig_s && !busy) begin
            hold    <= cap;
            req_tog <= ~req_tog;
         end
         // core clock is slower: beats that meet a busy handshake are lost
         if (gig_s && busy && (cap.en || cap.er))
            overrun <= 1'b1;
      end
   end

   hold_stable_a: assert property (@(posedge gtx_clk) disable iff (!rs_n)
      busy |=> $stable(hold))
      else $error("hold word changed during handshake");

endmodule : gmp_tx_sampler

//--- core/gmp_rx_driver.sv
// receive side toward the MAC: RX_CLK divider and registered outputs
// assumes the core offers one symbol per RX_CLK period
`timescale 1ns/1ps
`include "gmp_regs.svh"
module gmp_rx_driver #(
   parameter int unsigned DIV = `GMP_RX_CLK_DIV
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // mode and symbol
   input  wire logic                 gig,
   input  gmp_pkg::gmp_sym_t         sym,
   // MAC pins, plus the take strobe back to the core
   output logic                      rx_clk,
   output logic [7:0]                rxd,
   output logic                      rx_dv,
   output logic                      rx_er,
   output logic                      take
);
   localparam int unsigned W = (DIV > 2) ? $clog2(DIV) : 1;

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         upd;

   assign next_cnt = (cnt == W'(DIV - 1)) ? '0 : cnt + 1'b1;
   assign upd      = next_cnt == '0;

   // outputs move on the falling RX_CLK edge so they are settled at the rise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt    <= '0;
         rx_clk <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         rx_clk <= next_cnt >= W'(DIV / 2);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxd   <= 8'h00;
         rx_dv <= 1'b0;
         rx_er <= 1'b0;
         take  <= 1'b0;
      end else begin
         take <= upd;
         if (upd) begin
            rx_dv <= sym.valid;
            rx_er <= sym.valid ? sym.err : sym.lpi;
            if (sym.valid)
               rxd <= gig ? sym.data : (sym.data & `GMP_NIB_MASK);
            else
               rxd <= sym.lpi ? `GMP_LPI_CODE : 8'h00;
         end
      end
   end

   rxd_upper_a: assert property (@(posedge clk) disable iff (!rstn)
      take && !$past(gig) |-> rxd[7:4] == 4'h0)
      else $error("upper receive nibble driven in MII mode");

   rx_edge_a: assert property (@(posedge clk) disable iff (!rstn)
      $changed(rx_dv) || $changed(rx_er) || $changed(rxd) |-> $fell(rx_clk))
      else $error("receive outputs moved off the RX_CLK falling edge");

   rx_lpi_a: assert property (@(posedge clk) disable iff (!rstn)
      take && !$past(sym.valid) && $past(sym.lpi)
      |-> rx_er && !rx_dv && rxd == `GMP_LPI_CODE)
      else $error("low power idle not signalled on receive");

   rx_valid_a: assert property (@(posedge clk) disable iff (!rstn)
      take |-> rx_dv == $past(sym.valid) ##1 $stable(rx_dv))
      else $error("RX_DV does not follow the offered symbol");

endmodule : gmp_rx_driver

//--- testbench/gmp_mac_model.sv
// MAC-side partner model: transmit pins and the GMII transmit clock
// assumes CLK comes from the bench and TX_CLK from the port; the bench calls the tasks
`timescale 1ns/1ps
module gmp_mac_model (
   // clocks and mode
   input  wire logic       clk,
   input  wire logic       tx_clk,
   input  wire logic       gig,
   output logic            gtx_clk,
   // transmit pins
   output logic [7:0]      txd,
   output logic            tx_en,
   output logic            tx_er
);
   initial begin
      gtx_clk = 1'h0;
      txd     = 8'h00;
      tx_en   = 1'h0;
      tx_er   = 1'h0;
      #7;
      // held low outside gigabit, as a pull-down would
      forever #15 gtx_clk = gig ? ~gtx_clk : 1'h0;
   end

   // nibble beat held one TX_CLK period; idle periods model a slow MAC
   task automatic mii_beat(input logic [7:0] d, input logic en, input logic er,
                           input int idle);
      @(posedge tx_clk);
      @(negedge clk);
      txd   = d;
      tx_en = en;
      tx_er = er;
      repeat (idle) begin
         @(posedge tx_clk);
         @(negedge clk);
         txd   = ~d;
         tx_en = 1'h0;
         tx_er = 1'h0;
      end
   endtask : mii_beat

   // byte held for n GTX_CLK periods, then released to idle
   task automatic gmii_beat(input logic [7:0] d, input logic en, input int n);
      @(posedge gtx_clk);
      #1;
      txd   = d;
      tx_en = en;
      repeat (n) @(posedge gtx_clk);
      #1;
      txd   = ~d;
      tx_en = 1'h0;
      tx_er = 1'h0;
   endtask : gmii_beat
endmodule : gmp_mac_model

//--- testbench/gmp_port_tb_top.sv
// self-checking bench for the GMII/MII port
// assumes the MAC model drives the transmit pins; bench plays the core side
`timescale 1ns/1ps
module gmp_port_tb_top;
   logic              CLK, RSTN, GTX_CLK, TX_EN, TX_ER, TX_CLK, RX_CLK;
   logic [7:0]        TXD, RXD;
   logic              RX_DV, RX_ER, CRS, COL, GIG_MODE, HALF_DUPLEX, MDIX;
   logic              LINE_CARRIER, LINE_COLLISION, RX_TAKE, TX_FRAME_BAD, TX_OVERRUN;
   logic [3:0]        PAIR_TX_EN, PAIR_RX_EN;
   gmp_pkg::gmp_sym_t RX_SYM, TX_SYM;
   gmp_pkg::gmp_sym_t got_q[$];
   int                failures, samples_checked, bad_ends;

   gmp_port #(.TX_DIV(4), .RX_DIV(4)) gmp_port_i (
      .CLK(CLK), .RSTN(RSTN), .GTX_CLK(GTX_CLK), .TXD(TXD), .TX_EN(TX_EN),
      .TX_ER(TX_ER), .TX_CLK(TX_CLK), .RX_CLK(RX_CLK), .RXD(RXD), .RX_DV(RX_DV),
      .RX_ER(RX_ER), .CRS(CRS), .COL(COL), .GIG_MODE(GIG_MODE),
      .HALF_DUPLEX(HALF_DUPLEX), .MDIX(MDIX), .LINE_CARRIER(LINE_CARRIER),
      .LINE_COLLISION(LINE_COLLISION), .RX_SYM(RX_SYM), .RX_TAKE(RX_TAKE),
      .TX_SYM(TX_SYM), .TX_FRAME_BAD(TX_FRAME_BAD), .TX_OVERRUN(TX_OVERRUN),
      .PAIR_TX_EN(PAIR_TX_EN), .PAIR_RX_EN(PAIR_RX_EN));

   gmp_mac_model gmp_mac_model_i (
      .clk(CLK), .tx_clk(TX_CLK), .gig(GIG_MODE), .gtx_clk(GTX_CLK),
      .txd(TXD), .tx_en(TX_EN), .tx_er(TX_ER));

   initial begin
      CLK = 1'h0;
      forever #25 CLK = ~CLK;
   end

   // collects every transmit beat the port hands to the encoder, mid-cycle where settled
   always @(negedge CLK) begin
      if (TX_SYM.valid === 1'h1)
         got_q.push_back(TX_SYM);
      if (TX_FRAME_BAD === 1'h1)
         bad_ends++;
   end

   task automatic summarize();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic give_up(input string what);
      failures++;
      $display("BAD t=%0t %s", $time, what);
      summarize();
   endtask : give_up

   task automatic tick(input int n);
      repeat (n) @(negedge CLK);
   endtask : tick

   task automatic pop_sym(input logic [7:0] d, input logic er);
      gmp_pkg::gmp_sym_t s;
      if (got_q.size() == 0)
         give_up("transmit beat missing");
      s = got_q.pop_front();
      chk(16'({s.err, s.data}), 16'({er, d}), "tx beat");
   endtask : pop_sym

   task automatic wait_take();
      int n;
      n = 0;
      do begin
         @(negedge CLK);
         n++;
      end while (RX_TAKE !== 1'h1 && n < 12);
      if (RX_TAKE !== 1'h1)
         give_up("no receive take");
   endtask : wait_take

   // present one symbol, then judge the pins once the port has taken it
   task automatic rx_one(input logic v, input logic e, input logic l,
                         input logic [7:0] d, input logic [9:0] exp);
      wait_take();
      RX_SYM = {v, e, l, d};
      wait_take();
      chk(16'(RX_CLK), 16'h0000, "rx clock phase");
      chk(16'({RXD, RX_DV, RX_ER}), 16'(exp), "rx pins");
   endtask : rx_one

   task automatic t_gmii();
      chk(16'(TX_OVERRUN), 16'h0000, "overrun idle");
      got_q.delete();
      gmp_mac_model_i.gmii_beat(8'hC6, 1'h1, 10);
      tick(20);
      if (got_q.size() == 0)
         give_up("no gigabit beat");
      while (got_q.size() > 0)
         pop_sym(8'hC6, 1'h0);
      // a byte held longer than one crossing must be partly dropped
      chk(16'(TX_OVERRUN), 16'h0001, "overrun");
      $display("test gmii done");
   endtask : t_gmii

   task automatic t_pairs();
      logic [1:0] m;
      for (int i = 0; i < 3; i++) begin
         m = 2'(i);
         GIG_MODE = (m == 2'h2);
         MDIX = m[0];
         tick(3);
         chk(16'(PAIR_TX_EN), m == 2'h2 ? 16'h000F : 16'(m[0] ? 2'h2 : 2'h1), "ptx");
         chk(16'(PAIR_RX_EN), m == 2'h2 ? 16'h000F : 16'(m[0] ? 2'h1 : 2'h2), "prx");
      end
      $display("test pairs done");
   endtask : t_pairs

   task automatic t_status();
      for (int i = 0; i < 8; i++) begin
         {HALF_DUPLEX, LINE_CARRIER, LINE_COLLISION} = 3'(i);
         tick(2);
         chk(16'({CRS, COL}), 16'({i[2] & i[1], i[2] & i[0]}), "crs col");
      end
      $display("test status done");
   endtask : t_status

   task automatic t_rx();
      GIG_MODE = 1'h1;
      rx_one(1'h1, 1'h0, 1'h0, 8'hA5, 10'h296);
      rx_one(1'h1, 1'h1, 1'h0, 8'h3C, 10'h0F3);
      rx_one(1'h0, 1'h0, 1'h1, 8'h00, 10'h005);
      rx_one(1'h0, 1'h0, 1'h0, 8'h77, 10'h000);
      GIG_MODE = 1'h0;
      rx_one(1'h1, 1'h0, 1'h0, 8'hA5, 10'h016);
      rx_one(1'h0, 1'h0, 1'h1, 8'h00, 10'h005);
      $display("test rx done");
   endtask : t_rx

   task automatic t_clocks();
      int tx_up, rx_up;
      logic tp, rp;
      for (int g = 0; g < 2; g++) begin
         GIG_MODE = g[0];
         tick(4);
         tx_up = 0;
         rx_up = 0;
         tp = TX_CLK;
         rp = RX_CLK;
         repeat (40) begin
            @(negedge CLK);
            tx_up += int'(TX_CLK === 1'h1 && tp === 1'h0);
            rx_up += int'(RX_CLK === 1'h1 && rp === 1'h0);
            tp = TX_CLK;
            rp = RX_CLK;
         end
         chk(16'(tx_up), g ? 16'h0000 : 16'h000A, "tx clock rises");
         chk(16'(rx_up), 16'h000A, "rx clock rises");
      end
      $display("test clocks done");
   endtask : t_clocks

   task automatic t_tx_mii();
      GIG_MODE = 1'h0;
      tick(8);
      got_q.delete();
      bad_ends = 0;
      gmp_mac_model_i.mii_beat(8'hA3, 1'h1, 1'h0, 0);
      gmp_mac_model_i.mii_beat(8'h5C, 1'h1, 1'h1, 0);
      gmp_mac_model_i.mii_beat(8'hE7, 1'h1, 1'h0, 2);
      gmp_mac_model_i.mii_beat(8'h00, 1'h0, 1'h0, 0);
      tick(12);
      pop_sym(8'h03, 1'h0);
      pop_sym(8'h0C, 1'h1);
      pop_sym(8'h07, 1'h1);
      chk(16'(got_q.size()), 16'h0000, "idle beats");
      chk(16'(bad_ends), 16'h0001, "errored frame end");
      $display("test tx mii done");
   endtask : t_tx_mii

   task automatic t_lpi();
      gmp_mac_model_i.mii_beat(8'h01, 1'h0, 1'h1, 0);
      tick(8);
      chk(16'(TX_SYM.lpi), 16'h0001, "lpi request");
      gmp_mac_model_i.mii_beat(8'h00, 1'h0, 1'h0, 0);
      tick(8);
      chk(16'(TX_SYM.lpi), 16'h0000, "lpi exit");
      gmp_mac_model_i.mii_beat(8'h33, 1'h0, 1'h1, 0);
      tick(8);
      chk(16'(TX_SYM.lpi), 16'h0000, "not lpi code");
      gmp_mac_model_i.mii_beat(8'h00, 1'h0, 1'h0, 0);
      $display("test lpi done");
   endtask : t_lpi

   // cuts a hang short
   initial begin
      #2000000;
      give_up("run limit reached");
   end

   initial begin
      failures        = 0;
      samples_checked = 0;
      bad_ends        = 0;
      RSTN            = 1'h0;
      GIG_MODE        = 1'h1;
      HALF_DUPLEX     = 1'h0;
      MDIX            = 1'h0;
      LINE_CARRIER    = 1'h0;
      LINE_COLLISION  = 1'h0;
      RX_SYM          = '0;
      tick(12);
      chk(16'({RX_DV, RX_ER, TX_CLK, RX_CLK, PAIR_TX_EN, PAIR_RX_EN}), 16'h0000, "reset");
      RSTN = 1'h1;
      tick(10);
      t_gmii();
      t_pairs();
      t_status();
      t_rx();
      t_clocks();
      t_tx_mii();
      t_lpi();
      summarize();
   end
endmodule : gmp_port_tb_top
